//--- hw/ufl_top.sv
// FIFO control and line control of the serial port
//
// How it works
// - FIFO control is write-only and shares its location with the read-only interrupt identification.
// - Bits 7:6 of FIFO control pick a receive trigger of 1, 4, 8 or 14 bytes.
// - Writing one to bit 2 zeroes the transmit count and the bit is never stored.
// - Writing one to bit 1 zeroes the receive count and the bit is never stored.
// - Setting bit 0 enables both FIFOs and clearing it empties both.
// - Any change between FIFO mode and character mode empties both FIFOs.
// - A FIFO control write with bit 0 at zero programs none of the other bits.
// - Line control reads back whatever was last written to it.
// - The divisor-latch access bit selects the divisor latches at the shared locations.
// - While break is set the serial output is held low and the shifter runs on.
// - Stick parity sends and checks a fixed bit, zero when even select is one.
// - Without stick, parity is odd when even select is zero and even when it is one.
// - Parity enable adds a parity bit after the last data bit on both directions.
// - Bits 1:0 of line control give five to eight data bits for both directions.
// - Stop select gives one stop bit, or one and a half for five bits, else two.
// - With divisor access set, the enable location holds the divisor high byte.
`include "ufl_defs.svh"
`default_nettype none
module ufl_top (
    input wire logic CLK_SYS_I,
    input wire logic RST_I,
    input wire ufl_pkg::ufl_bus_req_t BUS_REQ_I,
    output logic [7:0] RD_DATA_O,
    input wire logic [3:0] INT_ID_I,
    input wire ufl_pkg::ufl_fifo_ev_t TX_EV_I,
    input wire ufl_pkg::ufl_fifo_ev_t RX_EV_I,
    output logic [4:0] TX_COUNT_O,
    output logic [4:0] RX_COUNT_O,
    output logic RX_TRIG_O,
    output logic FIFO_EN_O,
    input wire logic TX_SERIAL_I,
    output logic SERIAL_OUTPUT_O,
    input wire logic [7:0] TX_DATA_I,
    output logic TX_PARITY_O,
    input wire logic RX_CHECK_I,
    input wire logic [7:0] RX_DATA_I,
    input wire logic RX_PARITY_I,
    output ufl_pkg::ufl_line_cfg_t LINE_CFG_O,
    output logic [15:0] DIVISOR_O,
    output logic [3:0] INT_ENABLE_O,
    output logic IRQ_O
);

    // ----------------------------------------
    // Register state
    // ----------------------------------------
    logic fifo_en_q;
    logic [1:0] trig_sel_q;
    logic [7:0] line_q;
    logic [7:0] div_lo_q;
    logic [7:0] div_hi_q;
    logic [3:0] ier_q;
    logic [3:0] isr_q;
    logic [3:0] imr_q;
    logic [7:0] rdata_q;
    logic [4:0] cnt_q [2];
    logic [4:0] cnt_d [2];
    logic trig_q;
    logic serial_q;
    logic tx_par_q;

    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    wire logic [7:0] adr = BUS_REQ_I.addr;
    wire logic [7:0] wd = BUS_REQ_I.wdata;
    wire logic div_acc = line_q[`UFL_LINE_DIVACC];
    wire logic hit_dat = adr == `UFL_OFF_DATA;
    wire logic hit_ier = adr == `UFL_OFF_IER;
    wire logic hit_iid = adr == `UFL_OFF_IID;
    wire logic hit_line = adr == `UFL_OFF_LINE;
    wire logic hit_isr = adr == `UFL_OFF_ISR;
    wire logic hit_imr = adr == `UFL_OFF_IMR;
    wire logic fctl_wr = BUS_REQ_I.wr & hit_iid;
    wire logic line_wr = BUS_REQ_I.wr & hit_line;
    wire logic dll_wr = BUS_REQ_I.wr & hit_dat & div_acc;
    wire logic div_hi_wr = BUS_REQ_I.wr & hit_ier & div_acc;
    wire logic ier_wr = BUS_REQ_I.wr & hit_ier & ~div_acc;
    wire logic isr_wr = BUS_REQ_I.wr & hit_isr;
    wire logic imr_wr = BUS_REQ_I.wr & hit_imr;

    // ----------------------------------------
    // FIFO control decode
    // ----------------------------------------
    wire logic wr_en = wd[`UFL_FCTL_EN];
    wire logic mode_chg = fctl_wr & (wr_en != fifo_en_q);
    // flush bits only count with enable
    wire logic tx_fl = fctl_wr & wr_en & wd[`UFL_FCTL_TXF];
    wire logic rx_fl = fctl_wr & wr_en & wd[`UFL_FCTL_RXF];
    wire logic flush [2];
    assign flush[0] = tx_fl | mode_chg;
    assign flush[1] = rx_fl | mode_chg;

    // Enable, trigger select; flush bits never stored
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            fifo_en_q <= 1'b0;
            trig_sel_q <= 2'b00;
        end else if (fctl_wr) begin
            fifo_en_q <= wr_en;
            if (wr_en) begin
                trig_sel_q <= wd[`UFL_FCTL_TRG_HI:`UFL_FCTL_TRG_LO];
            end
        end
    end

    // ----------------------------------------
    // FIFO occupancy counters
    // ----------------------------------------
    ufl_pkg::ufl_fifo_ev_t ev [2];
    logic do_push [2];
    logic do_pop [2];
    logic full [2];
    assign ev[0] = TX_EV_I;
    assign ev[1] = RX_EV_I;

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_fifo
            assign full[g] = cnt_q[g] == `UFL_FIFO_DEPTH;
            assign do_push[g] = fifo_en_q & ev[g].push & ~full[g];
            assign do_pop[g] = fifo_en_q & ev[g].pop & (cnt_q[g] != 5'h00);
            assign cnt_d[g] = flush[g] ? 5'h00 :
                cnt_q[g] + {4'h0, do_push[g]} - {4'h0, do_pop[g]};
            always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
                if (RST_I) begin
                    cnt_q[g] <= 5'h00;
                end else begin
                    cnt_q[g] <= cnt_d[g];
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // Receive trigger compare
    // ----------------------------------------
    // trigger level decode
    wire logic [4:0] trig_lvl = (trig_sel_q == 2'b00) ? `UFL_TRIG_00 :
                                (trig_sel_q == 2'b01) ? `UFL_TRIG_01 :
                                (trig_sel_q == 2'b10) ? `UFL_TRIG_10 :
                                `UFL_TRIG_11;
    wire logic trig_now = fifo_en_q & (cnt_q[1] >= trig_lvl);

    // ----------------------------------------
    // Line control, divisor, enables
    // ----------------------------------------
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            line_q <= `UFL_LINE_RST;
            div_lo_q <= `UFL_DIV_RST;
            div_hi_q <= `UFL_DIV_RST;
            ier_q <= 4'h0;
            imr_q <= 4'h0;
        end else begin
            // full byte kept for read back
            if (line_wr) line_q <= wd;
            if (dll_wr) div_lo_q <= wd;
            if (div_hi_wr) div_hi_q <= wd;
            if (ier_wr) ier_q <= wd[3:0];
            if (imr_wr) imr_q <= wd[3:0];
        end
    end

    // ----------------------------------------
    // Character format
    // ----------------------------------------
    wire logic [1:0] wls = line_q[`UFL_LINE_WLS_HI:`UFL_LINE_WLS_LO];
    wire logic pen = line_q[`UFL_LINE_PEN];
    wire logic eps = line_q[`UFL_LINE_EPS];
    wire logic stick = line_q[`UFL_LINE_STICK];
    wire logic stop_sel = line_q[`UFL_LINE_STOP];
    assign LINE_CFG_O.char_bits = {2'b00, wls} + 4'h5;
    // half stop only for five bits
    assign LINE_CFG_O.stop_half = stop_sel & (wls == 2'b00);
    assign LINE_CFG_O.stop_two = stop_sel & (wls != 2'b00);
    assign LINE_CFG_O.parity_en = pen;

    // Parity bit to send for a character
    function automatic logic par_of(input logic [7:0] d,
                                    input logic [1:0] w,
                                    input logic e,
                                    input logic s);
        logic [7:0] m;
        m = 8'hff >> (2'b11 - w);
        if (s) begin
            return ~e;
        end
        // even or odd over data plus parity
        return e ? ^(d & m) : ~^(d & m);
    endfunction

    wire logic tx_par = par_of(TX_DATA_I, wls, eps, stick);
    wire logic rx_exp = par_of(RX_DATA_I, wls, eps, stick);
    wire logic par_err = RX_CHECK_I & pen & (RX_PARITY_I != rx_exp);

    // Parity and break-forced serial line
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            tx_par_q <= 1'b0;
            serial_q <= 1'b1;
            trig_q <= 1'b0;
        end else begin
            tx_par_q <= tx_par;
            serial_q <= TX_SERIAL_I & ~line_q[`UFL_LINE_BRK];
            trig_q <= trig_now;
        end
    end

    // ----------------------------------------
    // Interrupt status
    // ----------------------------------------
    wire logic [3:0] ev_set = {
        RX_EV_I.push & fifo_en_q & full[1],
        par_err,
        do_pop[0] & (cnt_q[0] == 5'h01) & ~flush[0],
        trig_now & ~trig_q
    };
    wire logic [3:0] isr_clr = isr_wr ? wd[3:0] : 4'h0;
    wire logic [3:0] isr_d = (isr_q & ~isr_clr) | ev_set;

    // Sticky bits, set wins over clear
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            isr_q <= 4'h0;
        end else begin
            isr_q <= isr_d;
        end
    end

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    // read side shows identification
    wire logic [7:0] iid_rd = {fifo_en_q, fifo_en_q, 2'b00, INT_ID_I};
    wire logic [7:0] dat_rd = div_acc ? div_lo_q : 8'h00;
    wire logic [7:0] ier_rd = div_acc ? div_hi_q : {4'h0, ier_q};
    wire logic [7:0] rd_mux = hit_dat ? dat_rd :
                              hit_ier ? ier_rd :
                              hit_iid ? iid_rd :
                              hit_line ? line_q :
                              hit_isr ? {4'h0, isr_q} :
                              hit_imr ? {4'h0, imr_q} : 8'h00;

    // Read data for one cycle only
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= BUS_REQ_I.rd ? rd_mux : 8'h00;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign RD_DATA_O = rdata_q;
    assign TX_COUNT_O = cnt_q[0];
    assign RX_COUNT_O = cnt_q[1];
    assign RX_TRIG_O = trig_q;
    assign FIFO_EN_O = fifo_en_q;
    assign SERIAL_OUTPUT_O = serial_q;
    assign TX_PARITY_O = tx_par_q;
    assign DIVISOR_O = {div_hi_q, div_lo_q};
    assign INT_ENABLE_O = ier_q;
    assign IRQ_O = |(isr_q & imr_q);

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_ctl_reads_id: assert property (
        @(posedge CLK_SYS_I) disable iff (RST_I)
        BUS_REQ_I.rd && hit_iid |=>
        RD_DATA_O == {$past(fifo_en_q), $past(fifo_en_q), 2'b00,
                      $past(INT_ID_I)})
        else $error("identification read mismatch");
    a_trig_level_14: assert property (
        @(posedge CLK_SYS_I) disable iff (RST_I)
        fifo_en_q && trig_sel_q == 2'b11 && cnt_q[1] == 5'h0d
        |=> !trig_q)
        else $error("trigger below 14");
    a_tx_flush_zero: assert property (
        @(posedge CLK_SYS_I) disable iff (RST_I)
        fctl_wr && wd[0] && wd[2] |=> TX_COUNT_O == 5'h00)
        else $error("tx flush failed");
    a_rx_flush_zero: assert property (
        @(posedge CLK_SYS_I) disable iff (RST_I)
        fctl_wr && wd[0] && wd[1] |=> RX_COUNT_O == 5'h00)
        else $error("rx flush failed");
    a_disabled_empty: assert property (
        @(posedge CLK_SYS_I) disable iff (RST_I)
        !fifo_en_q |-> TX_COUNT_O == 5'h00 && RX_COUNT_O == 5'h00)
        else $error("count while disabled");
    a_mode_chg_clear: assert property (
        @(posedge CLK_SYS_I) disable iff (RST_I)
        $changed(fifo_en_q) |-> RX_COUNT_O == 5'h00 && TX_COUNT_O == 5'h00)
        else $error("mode change kept data");
    a_trig_ignored: assert property (
        @(posedge CLK_SYS_I) disable iff (RST_I)
        fctl_wr && !wd[0] |=> $stable(trig_sel_q))
        else $error("trigger set without enable");
    a_line_readback: assert property (
        @(posedge CLK_SYS_I) disable iff (RST_I)
        line_wr ##1 BUS_REQ_I.rd && hit_line && !BUS_REQ_I.wr
        |=> RD_DATA_O == $past(wd, 2))
        else $error("line control read back wrong");
    a_break_low: assert property (
        @(posedge CLK_SYS_I) disable iff (RST_I)
        line_q[`UFL_LINE_BRK] |=> !SERIAL_OUTPUT_O)
        else $error("break not forced");
    a_stick_parity: assert property (
        @(posedge CLK_SYS_I) disable iff (RST_I)
        stick && $stable(line_q) |=> TX_PARITY_O == !$past(eps))
        else $error("stick parity wrong");
    a_div_hi_write: assert property (
        @(posedge CLK_SYS_I) disable iff (RST_I)
        div_hi_wr |=> DIVISOR_O[15:8] == $past(wd) && $stable(ier_q))
        else $error("divisor high byte");

endmodule
`default_nettype wire

//--- hw/ufl_defs.svh
// Offsets, field positions, reset values and counts of the line control
`ifndef UFL_DEFS_SVH
`define UFL_DEFS_SVH
`define UFL_OFF_DATA 8'h00
`define UFL_OFF_IER 8'h04
`define UFL_OFF_IID 8'h08
`define UFL_OFF_LINE 8'h0c
`define UFL_OFF_ISR 8'h10
`define UFL_OFF_IMR 8'h14
`define UFL_FCTL_EN 0
`define UFL_FCTL_RXF 1
`define UFL_FCTL_TXF 2
`define UFL_FCTL_TRG_HI 7
`define UFL_FCTL_TRG_LO 6
`define UFL_LINE_WLS_HI 1
`define UFL_LINE_WLS_LO 0
`define UFL_LINE_STOP 2
`define UFL_LINE_PEN 3
`define UFL_LINE_EPS 4
`define UFL_LINE_STICK 5
`define UFL_LINE_BRK 6
`define UFL_LINE_DIVACC 7
`define UFL_TRIG_00 5'h01
`define UFL_TRIG_01 5'h04
`define UFL_TRIG_10 5'h08
`define UFL_TRIG_11 5'h0e
`define UFL_FIFO_DEPTH 5'h10
`define UFL_LINE_RST 8'h00
`define UFL_DIV_RST 8'h00
`define UFL_EV_RXTRIG 0
`define UFL_EV_TXEMPTY 1
`define UFL_EV_PARERR 2
`define UFL_EV_RXOVF 3
`endif

//--- hw/ufl_pkg.sv
// Types shared by the line control block
`default_nettype none
package ufl_pkg;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } ufl_bus_req_t;
    typedef struct packed {
        logic push;
        logic pop;
    } ufl_fifo_ev_t;
    typedef struct packed {
        logic [3:0] char_bits;
        logic stop_half;
        logic stop_two;
        logic parity_en;
    } ufl_line_cfg_t;
endpackage
`default_nettype wire

//--- verification/ufl_line_partner.sv
// Far-end terminal model that hands received characters to the checker
`default_nettype none
module ufl_line_partner (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic send_i,
    input wire logic bad_i,
    input wire logic [7:0] data_i,
    input wire logic [1:0] wls_i,
    input wire logic eps_i,
    input wire logic stick_i,
    output logic check_o,
    output logic [7:0] data_o,
    output logic parity_o
);
    logic [7:0] dm;
    logic par;
    assign dm = data_i & (8'hff >> (3 - wls_i));
    assign par = stick_i ? ~eps_i : (eps_i ? ^dm : ~^dm);
    // Strobe one character, scramble released lines between
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            check_o <= 1'b0;
            data_o <= 8'h00;
            parity_o <= 1'b0;
        end else begin
            check_o <= send_i;
            data_o <= send_i ? dm : ~data_o;
            parity_o <= send_i ? (par ^ bad_i) : ~parity_o;
        end
    end
endmodule
`default_nettype wire

//--- verification/uart_fifo_line_control_tb_top.sv
// Self-checking bench for the FIFO and line control block
`include "ufl_defs.svh"
`default_nettype none
`define UFL_CHK(nm, ex, gt) \
    begin \
        num_checks++; \
        if ((gt) !== (ex)) begin \
            failures++; \
            $display("wrong value %s exp %0h got %0h", nm, ex, gt); \
        end \
    end
module uart_fifo_line_control_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    ufl_pkg::ufl_bus_req_t bus;
    ufl_pkg::ufl_fifo_ev_t tx_ev;
    ufl_pkg::ufl_fifo_ev_t rx_ev;
    ufl_pkg::ufl_line_cfg_t cfg;
    logic [7:0] rd_data;
    logic [3:0] int_id;
    logic [4:0] tx_cnt;
    logic [4:0] rx_cnt;
    logic trig, fen, tx_ser, ser_out, tx_par, rx_chk, rx_par, irq;
    logic [7:0] tx_data;
    logic [7:0] rx_dat;
    logic [15:0] divisor;
    logic [3:0] int_en;
    logic send, bad;
    logic [7:0] pdata;
    logic [4:0] cfgk;
    logic [7:0] v;
    int failures = 0;
    int num_checks = 0;
    int cycles = 0;
    int rxc;
    int trg[4] = '{1, 4, 8, 14};

    always #5 clk = ~clk;

    ufl_top u_ufl_top (
        .CLK_SYS_I(clk), .RST_I(rst), .BUS_REQ_I(bus), .RD_DATA_O(rd_data),
        .INT_ID_I(int_id), .TX_EV_I(tx_ev), .RX_EV_I(rx_ev),
        .TX_COUNT_O(tx_cnt), .RX_COUNT_O(rx_cnt), .RX_TRIG_O(trig),
        .FIFO_EN_O(fen), .TX_SERIAL_I(tx_ser), .SERIAL_OUTPUT_O(ser_out),
        .TX_DATA_I(tx_data), .TX_PARITY_O(tx_par), .RX_CHECK_I(rx_chk),
        .RX_DATA_I(rx_dat), .RX_PARITY_I(rx_par), .LINE_CFG_O(cfg),
        .DIVISOR_O(divisor), .INT_ENABLE_O(int_en), .IRQ_O(irq)
    );

    ufl_line_partner u_ufl_line_partner (
        .clk_i(clk), .rst_i(rst), .send_i(send), .bad_i(bad),
        .data_i(pdata), .wls_i(cfgk[4:3]), .eps_i(cfgk[2]),
        .stick_i(cfgk[1]), .check_o(rx_chk), .data_o(rx_dat),
        .parity_o(rx_par)
    );

    // -------------------------------------------------------------
    // Bus and event tasks
    // -------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus.wr <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, input int ex, input string nm);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus.rd <= 1'b0;
        #1;
        `UFL_CHK(nm, ex[7:0], rd_data)
    endtask

    task automatic ev(input logic rx, input logic push, input logic pop);
        @(posedge clk);
        if (rx) rx_ev <= '{push: push, pop: pop};
        else tx_ev <= '{push: push, pop: pop};
        @(posedge clk);
        rx_ev <= '0;
        tx_ev <= '0;
        @(posedge clk);
        #1;
    endtask

    // Expected parity bit from the format code
    function automatic logic epar(input logic [7:0] d, input int k);
        logic [7:0] m;
        m = d & (8'hff >> (3 - k[4:3]));
        return k[1] ? ~k[2] : (k[2] ? ^m : ~^m);
    endfunction

    task automatic final_report;
        if (failures == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // Hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            failures++;
            final_report();
        end
    end

    // -------------------------------------------------------------
    // Main sequence
    // -------------------------------------------------------------
    initial begin
        bus = '0;
        tx_ev = '0;
        rx_ev = '0;
        int_id = 4'h0;
        tx_ser = 1'b1;
        tx_data = 8'h00;
        send = 1'b0;
        bad = 1'b0;
        pdata = 8'h00;
        cfgk = 5'h00;
        void'($urandom(32'h9f2e4369));
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rd(`UFL_OFF_LINE, 0, "line_control");
        `UFL_CHK("serial", 1, ser_out)
        `UFL_CHK("fifo_en", 0, fen)
        // Format readback and decode
        for (int i = 0; i < 8; i++) begin
            v = (8'($urandom()) & 8'h3c) | 8'(i % 4);
            wr(`UFL_OFF_LINE, v);
            rd(`UFL_OFF_LINE, v, "line_control");
            `UFL_CHK("char_bits", 5 + v[1:0], cfg.char_bits)
            `UFL_CHK("stop_two", v[2] && v[1:0] != 0, cfg.stop_two)
            `UFL_CHK("stop_half", v[2] && v[1:0] == 0, cfg.stop_half)
            `UFL_CHK("parity_en", v[3], cfg.parity_en)
        end
        // Divisor latches behind the access bit
        wr(`UFL_OFF_LINE, 8'h80);
        wr(`UFL_OFF_DATA, 8'h34);
        wr(`UFL_OFF_IER, 8'h12);
        `UFL_CHK("divisor", 16'h1234, divisor)
        rd(`UFL_OFF_IER, 8'h12, "divisor_high");
        wr(`UFL_OFF_LINE, 8'h00);
        wr(`UFL_OFF_IER, 8'h0b);
        `UFL_CHK("int_enable", 4'hb, int_en)
        `UFL_CHK("divisor", 16'h1234, divisor)
        rd(8'h18, 0, "unmapped");
        // Shared identification location
        v = 8'($urandom());
        int_id <= v[3:0];
        rd(`UFL_OFF_IID, {4'h0, v[3:0]}, "int_id");
        wr(`UFL_OFF_IID, 8'h01);
        `UFL_CHK("fifo_en", 1, fen)
        rd(`UFL_OFF_IID, {4'hc, v[3:0]}, "int_id");
        // Every trigger code: flush, then fill to overflow
        for (int c = 0; c < 4; c++) begin
            wr(`UFL_OFF_IID, {c[1:0], 6'h03});
            rxc = 0;
            `UFL_CHK("rx_count", 0, rx_cnt)
            for (int n = 0; n < 17; n++) begin
                ev(1'b1, 1'b1, 1'b0);
                if (rxc < 16) rxc++;
                `UFL_CHK("rx_count", rxc, rx_cnt)
                `UFL_CHK("rx_trig", rxc >= trg[c], trig)
            end
        end
        `UFL_CHK("irq", 0, irq)
        wr(`UFL_OFF_IMR, 8'h08);
        `UFL_CHK("irq", 1, irq)
        rd(`UFL_OFF_ISR, 8'h09, "status");
        // Transmit flush leaves the receive side
        repeat (3) ev(1'b0, 1'b1, 1'b0);
        `UFL_CHK("tx_count", 3, tx_cnt)
        wr(`UFL_OFF_IID, 8'h05);
        `UFL_CHK("tx_count", 0, tx_cnt)
        `UFL_CHK("rx_count", 16, rx_cnt)
        // Transmit count draining to zero raises its status bit
        ev(1'b0, 1'b1, 1'b0);
        ev(1'b0, 1'b0, 1'b1);
        `UFL_CHK("tx_count", 0, tx_cnt)
        rd(`UFL_OFF_ISR, 8'h0b, "status");
        // Leaving FIFO mode empties both sides
        ev(1'b0, 1'b1, 1'b0);
        wr(`UFL_OFF_IID, 8'hc0);
        `UFL_CHK("fifo_en", 0, fen)
        `UFL_CHK("rx_count", 0, rx_cnt)
        `UFL_CHK("tx_count", 0, tx_cnt)
        ev(1'b1, 1'b1, 1'b0);
        `UFL_CHK("rx_count", 0, rx_cnt)
        wr(`UFL_OFF_ISR, 8'h0f);
        rd(`UFL_OFF_ISR, 0, "status");
        // Break, parity generation and parity checking per format
        for (int k = 0; k < 32; k++) begin
            v = {1'b0, k[0], k[1], k[2], 1'b1, 1'b0, k[4:3]};
            cfgk <= k[4:0];
            wr(`UFL_OFF_LINE, v);
            repeat (4) begin
                @(posedge clk);
                tx_ser <= 1'($urandom());
                tx_data <= 8'($urandom());
                @(posedge clk);
                #1;
                `UFL_CHK("serial", k[0] ? 1'b0 : tx_ser, ser_out)
                `UFL_CHK("tx_parity", epar(tx_data, k), tx_par)
            end
            @(posedge clk);
            send <= 1'b1;
            bad <= k[0];
            pdata <= 8'($urandom());
            @(posedge clk);
            send <= 1'b0;
            repeat (3) @(posedge clk);
            #1;
            rd(`UFL_OFF_ISR, k[0] ? 4 : 0, "status");
            `UFL_CHK("irq", 0, irq)
            wr(`UFL_OFF_ISR, 8'h04);
        end
        final_report();
    end
endmodule
`undef UFL_CHK
`default_nettype wire
